// [logic/urx_pkg.sv]
// Shared constants and types of the serial receive block
package urx_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int STARTUP_NS = 1000;
   localparam int STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;
   localparam int STARTUP_W = $clog2(STARTUP_CYC + 1);
   localparam logic [STARTUP_W-1:0] STARTUP_LOAD = STARTUP_W'(STARTUP_CYC - 1);
   // ---------------------------------------------------------------
   // Oversampling points within one bit of sixteen ticks
   // ---------------------------------------------------------------
   localparam logic [3:0] SMP_A = 4'h7;
   localparam logic [3:0] SMP_B = 4'h8;
   localparam logic [3:0] SMP_C = 4'h9;
   localparam logic [3:0] SMP_LAST = 4'hF;
   localparam logic [3:0] LAST_BIT_9 = 4'h8;
   localparam logic [3:0] LAST_BIT_8 = 4'h7;
   // ---------------------------------------------------------------
   // Buffer and reset values
   // ---------------------------------------------------------------
   localparam int FIFO_DEPTH = 2;
   localparam logic [8:0] MASK_9 = 9'h1FF;
   localparam logic [8:0] MASK_8 = 9'h0FF;
   localparam logic [8:0] DATA_RST = 9'h000;
   localparam logic [7:0] BAUD_RST = 8'h00;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic frame_fault;
      logic parity_fault;
      logic noise;
      logic [8:0] data;
   } urx_word_t;
   localparam int WORD_W = $bits(urx_word_t);
   typedef struct packed {
      logic serial_port_on;
      logic receiver_on;
      logic nine_bit_select;
      logic parity_on;
      logic parity_odd;
      logic two_stop;
      logic address_match_mode;
      logic wake_enable;
   } urx_cfg_t;
   typedef struct packed {
      logic receive_irq_enable;
      logic tx_empty_irq_enable;
      logic tx_idle_irq_enable;
      logic global_irq_enable;
      logic group_irq_enable;
      logic port_irq_enable;
   } urx_irq_en_t;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_START = 6'h02,
      ST_DATA = 6'h04,
      ST_PARITY = 6'h08,
      ST_STOP1 = 6'h10,
      ST_STOP2 = 6'h20
   } urx_state_t;
endpackage

// [logic/urx_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module urx_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Pin and filtered level
   input wire logic pin_i,
   output logic level_o
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
      end else begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_o <= RESET_VAL;
      end else if (s2_reg == s3_reg) begin
         level_o <= s3_reg;
      end
   end
endmodule
`default_nettype wire

// [logic/urx_fifo.sv]
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module urx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic push;
   logic pop;

   assign in_ready_o = (count_reg != CNT_FULL);
   assign out_valid_o = (count_reg != '0);
   assign out_data_o = mem_reg[rd_ptr_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_ready_i && out_valid_o;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [logic/urx_top.sv]
// Serial receiver with error flags, interrupt combining and pin wake-up
`timescale 1ns/1ns
`default_nettype none
module urx_top
   import urx_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Serial line
   input wire logic rx_i,
   // Configuration
   input wire urx_cfg_t cfg_i,
   input wire urx_irq_en_t irq_en_i,
   input wire logic [7:0] baud_div_i,
   input wire logic port_clk_on_i,
   // Transmit-side conditions and processor state
   input wire logic tx_empty_i,
   input wire logic tx_idle_i,
   input wire logic stack_full_i,
   // Processor access strobes
   input wire logic status_access_i,
   input wire logic data_read_i,
   // Status and data
   output logic [8:0] rx_data_o,
   output logic rx_available_flag_o,
   output logic overflow_flag_o,
   output logic noise_flag_o,
   output logic frame_fault_flag_o,
   output logic parity_fault_flag_o,
   output logic rx_idle_o,
   // Requests
   output logic irq_n_o,
   output logic vector_req_o,
   output logic wake_o
);
   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_s1_reg;
   logic rst_n_reg;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_reg <= rst_s1_reg;
      end
   end

   // ---------------------------------------------------------------
   // Input synchroniser
   // ---------------------------------------------------------------
   logic rx_s;
   logic rx_prev_reg;

   urx_sync #(
      .RESET_VAL(1'b1)
   ) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_reg),
      .pin_i(rx_i),
      .level_o(rx_s)
   );

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rx_prev_reg <= 1'b1;
      end else begin
         rx_prev_reg <= rx_s;
      end
   end

   // ---------------------------------------------------------------
   // Wake-up and start-up delay
   // ---------------------------------------------------------------
   logic wake_arm;
   logic wake_evt;
   logic wake_pend_reg;
   logic startup_reg;
   logic wake_done_reg;
   logic [STARTUP_W-1:0] startup_cnt_reg;
   logic startup_busy;

   assign wake_arm = !port_clk_on_i && cfg_i.wake_enable && cfg_i.serial_port_on
                     && cfg_i.receiver_on && irq_en_i.receive_irq_enable;
   assign wake_evt = wake_arm && rx_prev_reg && !rx_s;
   assign startup_busy = wake_pend_reg || startup_reg;

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         wake_pend_reg <= 1'b0;
         startup_reg <= 1'b0;
         wake_done_reg <= 1'b0;
         startup_cnt_reg <= '0;
      end else begin
         wake_done_reg <= 1'b0;
         if (wake_evt) begin
            wake_pend_reg <= 1'b1;
         end else if (wake_pend_reg && port_clk_on_i) begin
            wake_pend_reg <= 1'b0;
            startup_reg <= 1'b1;
            startup_cnt_reg <= STARTUP_LOAD;
         end else if (startup_reg) begin
            if (startup_cnt_reg == '0) begin
               startup_reg <= 1'b0;
               wake_done_reg <= 1'b1;
            end else begin
               startup_cnt_reg <= startup_cnt_reg - 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         wake_o <= 1'b0;
      end else begin
         wake_o <= wake_evt;
      end
   end

   // ---------------------------------------------------------------
   // Oversampling tick
   // ---------------------------------------------------------------
   logic rx_on;
   logic run;
   logic tick;
   logic [7:0] baud_cnt_reg;

   assign rx_on = cfg_i.serial_port_on && cfg_i.receiver_on && !startup_busy;
   assign run = rx_on && port_clk_on_i;
   assign tick = run && (baud_cnt_reg == baud_div_i);

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         baud_cnt_reg <= BAUD_RST;
      end else if (!rx_on) begin
         baud_cnt_reg <= BAUD_RST;
      end else if (run) begin
         baud_cnt_reg <= tick ? BAUD_RST : baud_cnt_reg + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Bit timing and majority vote
   // ---------------------------------------------------------------
   urx_state_t state_reg;
   logic [3:0] scnt_reg;
   logic [2:0] smp_reg;
   logic bit_end;
   logic maj;
   logic noisy;

   assign bit_end = tick && (scnt_reg == SMP_LAST);
   assign maj = (smp_reg[0] & smp_reg[1]) | (smp_reg[0] & smp_reg[2])
                | (smp_reg[1] & smp_reg[2]);
   assign noisy = !((smp_reg == 3'h7) || (smp_reg == 3'h0));

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         scnt_reg <= '0;
      end else if (state_reg == ST_IDLE || !rx_on) begin
         scnt_reg <= '0;
      end else if (tick) begin
         scnt_reg <= scnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         smp_reg <= 3'h7;
      end else if (tick) begin
         if (scnt_reg == SMP_A) begin
            smp_reg[0] <= rx_s;
         end else if (scnt_reg == SMP_B) begin
            smp_reg[1] <= rx_s;
         end else if (scnt_reg == SMP_C) begin
            smp_reg[2] <= rx_s;
         end
      end
   end

   // ---------------------------------------------------------------
   // Frame state machine
   // ---------------------------------------------------------------
   logic [3:0] bit_cnt_reg;
   logic [8:0] shift_reg;
   logic par_bit_reg;
   logic noise_reg;
   logic frame_fault_flag_reg;
   logic seen_high_reg;
   logic [3:0] last_bit;

   assign last_bit = cfg_i.nine_bit_select ? LAST_BIT_9 : LAST_BIT_8;

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= '0;
         shift_reg <= DATA_RST;
         par_bit_reg <= 1'b0;
         noise_reg <= 1'b0;
         frame_fault_flag_reg <= 1'b0;
         seen_high_reg <= 1'b0;
      end else if (!rx_on) begin
         state_reg <= ST_IDLE;
         seen_high_reg <= 1'b0;
      end else if (port_clk_on_i) begin
         case (state_reg)
            ST_IDLE: begin
               if (rx_s) begin
                  seen_high_reg <= 1'b1;
               end
               if (tick && !rx_s && seen_high_reg) begin
                  state_reg <= ST_START;
               end
            end
            ST_START: begin
               if (bit_end) begin
                  if (!maj) begin
                     state_reg <= ST_DATA;
                     bit_cnt_reg <= '0;
                     shift_reg <= DATA_RST;
                     noise_reg <= noisy;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_DATA: begin
               if (bit_end) begin
                  shift_reg[bit_cnt_reg] <= maj;
                  noise_reg <= noise_reg | noisy;
                  bit_cnt_reg <= bit_cnt_reg + 1'b1;
                  if (bit_cnt_reg == last_bit) begin
                     state_reg <= cfg_i.parity_on ? ST_PARITY : ST_STOP1;
                  end
               end
            end
            ST_PARITY: begin
               if (bit_end) begin
                  par_bit_reg <= maj;
                  noise_reg <= noise_reg | noisy;
                  state_reg <= ST_STOP1;
               end
            end
            ST_STOP1: begin
               if (bit_end) begin
                  frame_fault_flag_reg <= !maj;
                  noise_reg <= noise_reg | noisy;
                  seen_high_reg <= 1'b0;
                  state_reg <= cfg_i.two_stop ? ST_STOP2 : ST_IDLE;
               end
            end
            ST_STOP2: begin
               if (bit_end) begin
                  seen_high_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Completed word
   // ---------------------------------------------------------------
   logic frame_done;
   logic [8:0] word_data;
   logic word_msb;
   urx_word_t word;

   assign frame_done = bit_end && ((state_reg == ST_STOP1 && !cfg_i.two_stop)
                                   || state_reg == ST_STOP2);
   assign word_data = shift_reg & (cfg_i.nine_bit_select ? MASK_9 : MASK_8);
   assign word_msb = cfg_i.nine_bit_select ? shift_reg[8] : shift_reg[7];
   assign word.data = word_data;
   assign word.noise = noise_reg | noisy;
   assign word.frame_fault = ((state_reg == ST_STOP2) && frame_fault_flag_reg) | !maj;
   assign word.parity_fault = cfg_i.parity_on
                              && ((^word_data ^ par_bit_reg) != cfg_i.parity_odd);

   // ---------------------------------------------------------------
   // Receive buffer and clear sequence
   // ---------------------------------------------------------------
   logic fifo_in_ready;
   logic fifo_out_valid;
   urx_word_t head;
   logic push_ok;
   logic ovr_evt;
   logic armed_reg;
   logic clear_seq;
   logic noise_set_reg;

   assign push_ok = frame_done && fifo_in_ready;
   assign ovr_evt = frame_done && !fifo_in_ready;
   assign clear_seq = data_read_i && armed_reg;

   urx_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n_reg),
      .in_valid_i(frame_done),
      .in_ready_o(fifo_in_ready),
      .in_data_i(word),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(clear_seq),
      .out_data_o(head)
   );

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         armed_reg <= 1'b0;
      end else if (data_read_i) begin
         armed_reg <= 1'b0;
      end else if (status_access_i) begin
         armed_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         overflow_flag_o <= 1'b0;
      end else if (ovr_evt) begin
         overflow_flag_o <= 1'b1;
      end else if (clear_seq) begin
         overflow_flag_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         noise_set_reg <= 1'b0;
         noise_flag_o <= 1'b0;
      end else begin
         noise_set_reg <= push_ok && word.noise;
         if (noise_set_reg) begin
            noise_flag_o <= 1'b1;
         end else if (clear_seq) begin
            noise_flag_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rx_data_o <= DATA_RST;
         rx_available_flag_o <= 1'b0;
         frame_fault_flag_o <= 1'b0;
         parity_fault_flag_o <= 1'b0;
         rx_idle_o <= 1'b1;
      end else begin
         rx_data_o <= fifo_out_valid ? head.data : DATA_RST;
         rx_available_flag_o <= fifo_out_valid;
         frame_fault_flag_o <= fifo_out_valid && head.frame_fault;
         parity_fault_flag_o <= fifo_out_valid && head.parity_fault;
         rx_idle_o <= (state_reg == ST_IDLE);
      end
   end

   // ---------------------------------------------------------------
   // Interrupt combining
   // ---------------------------------------------------------------
   logic tx_empty_prev_reg;
   logic tx_idle_prev_reg;
   logic tx_empty_evt;
   logic tx_idle_evt;
   logic rx_irq_evt;
   logic ovr_irq_evt;
   logic wake_irq_evt;
   logic irq_evt;
   logic cpu_irq_on;

   assign cpu_irq_on = irq_en_i.global_irq_enable && irq_en_i.group_irq_enable
                       && irq_en_i.port_irq_enable;
   assign tx_empty_evt = tx_empty_i && !tx_empty_prev_reg
                         && irq_en_i.tx_empty_irq_enable;
   assign tx_idle_evt = tx_idle_i && !tx_idle_prev_reg && irq_en_i.tx_idle_irq_enable;
   assign rx_irq_evt = push_ok && irq_en_i.receive_irq_enable
                       && (!cfg_i.address_match_mode || word_msb);
   assign ovr_irq_evt = ovr_evt && irq_en_i.receive_irq_enable;
   assign wake_irq_evt = wake_done_reg && cpu_irq_on;
   assign irq_evt = tx_empty_evt | tx_idle_evt | rx_irq_evt | ovr_irq_evt | wake_irq_evt;

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         tx_empty_prev_reg <= 1'b0;
         tx_idle_prev_reg <= 1'b0;
      end else begin
         tx_empty_prev_reg <= tx_empty_i;
         tx_idle_prev_reg <= tx_idle_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         irq_n_o <= 1'b1;
         vector_req_o <= 1'b0;
      end else begin
         irq_n_o <= !irq_evt;
         vector_req_o <= irq_evt && cpu_irq_on && !stack_full_i;
      end
   end
endmodule
`default_nettype wire

// [test/urx_sva.sv]
// Assertion checker for the serial receive block
`timescale 1ns/1ns
`default_nettype none
module urx_sva
   import urx_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Inputs
   input wire logic rx_i,
   input wire urx_cfg_t cfg_i,
   input wire urx_irq_en_t irq_en_i,
   input wire logic port_clk_on_i,
   input wire logic tx_empty_i,
   input wire logic stack_full_i,
   input wire logic data_read_i,
   // Outputs
   input wire logic [8:0] rx_data_o,
   input wire logic rx_available_flag_o,
   input wire logic overflow_flag_o,
   input wire logic noise_flag_o,
   input wire logic irq_n_o,
   input wire logic vector_req_o,
   input wire logic wake_o
);
   logic cpu_en;
   logic top_bit;
   logic arm;
   logic [2:0] rd_hist;
   assign cpu_en = irq_en_i.global_irq_enable & irq_en_i.group_irq_enable
      & irq_en_i.port_irq_enable;
   assign top_bit = cfg_i.nine_bit_select ? rx_data_o[8] : rx_data_o[7];
   assign arm = cfg_i.wake_enable & cfg_i.serial_port_on & cfg_i.receiver_on;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_hist <= 3'h0;
      end else begin
         rd_hist <= {rd_hist[1:0], data_read_i};
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_irq_low_pulse: assert property (!irq_n_o |=> irq_n_o)
      else $error("interrupt request low for more than one cycle");
   a_vector_gated: assert property (vector_req_o |-> !irq_n_o && cpu_en && !stack_full_i)
      else $error("vector request without all enables");
   a_vector_taken: assert property (!irq_n_o && cpu_en && !stack_full_i |-> vector_req_o)
      else $error("vector request missing");
   a_tx_empty_irq: assert property ($rose(tx_empty_i) && irq_en_i.tx_empty_irq_enable
      |-> ##[1:2] !irq_n_o) else $error("transmit empty interrupt missing");
   a_noise_with_data: assert property ($rose(noise_flag_o) |-> rx_available_flag_o)
      else $error("noise flag without stored word");
   a_avail_irq: assert property ($rose(rx_available_flag_o) && irq_en_i.receive_irq_enable
      && !cfg_i.address_match_mode |-> !$past(irq_n_o) || !$past(irq_n_o, 2))
      else $error("receive interrupt missing");
   a_addr_gate: assert property ($rose(rx_available_flag_o) && cfg_i.address_match_mode
      && !top_bit |-> $past(irq_n_o) && $past(irq_n_o, 2))
      else $error("interrupt on data word in address mode");
   a_wake_pulse: assert property ($fell(rx_i) && !port_clk_on_i && arm
      && irq_en_i.receive_irq_enable |-> ##[2:6] wake_o)
      else $error("wake request missing");
   a_overflow_clear: assert property ($fell(overflow_flag_o) |-> |rd_hist)
      else $error("overflow flag cleared without data read");
   a_noise_clear: assert property ($fell(noise_flag_o) |-> |rd_hist)
      else $error("noise flag cleared without data read");
   a_avail_clear: assert property ($fell(rx_available_flag_o) |-> |rd_hist)
      else $error("data available cleared without data read");
   c_overrun: cover property ($rose(overflow_flag_o));
   c_wake: cover property (wake_o);
   c_vector: cover property (vector_req_o);
endmodule
bind urx_top urx_sva u_urx_sva (.*);
`default_nettype wire

// [test/urx_line_model.sv]
// Remote serial transmitter driving the receive line
`timescale 1ns/1ns
`default_nettype none
module urx_line_model
   import urx_pkg::*;
#(
   parameter int BIT_CLK = 64
) (
   // Clock and agreed frame format
   input wire logic clk_i,
   input wire urx_cfg_t cfg_i,
   // Receive line
   output logic rx_o
);
   initial rx_o = 1'b1;
   // One bit time; a short mid-bit pulse disturbs a single sample
   task automatic put(input logic b, input logic glitch);
      for (int i = 0; i < BIT_CLK; i++) begin
         @(posedge clk_i);
         rx_o <= b ^ (glitch && i >= BIT_CLK / 2 && i < BIT_CLK / 2 + 4);
      end
   endtask
   // Faults: bit 0 low stop, bit 1 wrong parity, bit 2 noise
   task automatic send(input logic [8:0] w, input logic [2:0] f);
      logic [8:0] d;
      d = w & (cfg_i.nine_bit_select ? MASK_9 : MASK_8);
      put(1'b0, 1'b0);
      for (int k = 0; k < (cfg_i.nine_bit_select ? 9 : 8); k++) begin
         put(d[k], f[2] && k == 2);
      end
      if (cfg_i.parity_on) begin
         put(^d ^ cfg_i.parity_odd ^ f[1], 1'b0);
      end
      put(!(f[0] && !cfg_i.two_stop), 1'b0);
      if (cfg_i.two_stop) begin
         put(!f[0], 1'b0);
      end
      put(1'b1, 1'b0);
   endtask
endmodule
`default_nettype wire

// [test/tb.sv]
// Self-checking bench of the serial receive block
`timescale 1ns/1ns
`default_nettype none
module tb
   import urx_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic rx_i;
   urx_cfg_t cfg_i = '0;
   urx_irq_en_t irq_en_i = '0;
   logic [7:0] baud_div_i = 8'h03;
   logic port_clk_on_i = 1'b1;
   logic tx_empty_i = 1'b0;
   logic tx_idle_i = 1'b0;
   logic stack_full_i = 1'b0;
   logic status_access_i = 1'b0;
   logic data_read_i = 1'b0;
   logic [8:0] rx_data_o;
   logic rx_available_flag_o, overflow_flag_o, noise_flag_o, rx_idle_o;
   logic frame_fault_flag_o, parity_fault_flag_o, irq_n_o, vector_req_o, wake_o;
   logic [8:0] w;
   int error_cnt = 0;
   int n_checks = 0;
   int irqs = 0;
   int vecs = 0;
   int wakes = 0;
   int cyc = 0;
   int b, v;
   urx_top u_urx_top (.*);
   urx_line_model u_urx_line_model (.clk_i(clk_i), .cfg_i(cfg_i), .rx_o(rx_i));
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      irqs += (irq_n_o === 1'b0);
      vecs += (vector_req_o === 1'b1);
      wakes += (wake_o === 1'b1);
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         wrap_up();
      end
   end
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic with_status);
      @(posedge clk_i);
      status_access_i <= with_status;
      @(posedge clk_i);
      status_access_i <= 1'b0;
      data_read_i <= 1'b1;
      @(posedge clk_i);
      data_read_i <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
   task automatic rcv(input logic [8:0] wd, input logic [2:0] f);
      @(posedge clk_i);
      u_urx_line_model.send(wd, f);
      repeat (4) @(posedge clk_i);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      cfg_i.serial_port_on <= 1'b1;
      cfg_i.receiver_on <= 1'b1;
      irq_en_i <= 6'h3F;
      for (int k = 0; k < 2; k++) begin
         rcv(9'h05A ^ 9'(k), {k[0], 2'b00});
         chk(rx_data_o, 9'h05A ^ 9'(k), "data");
         chk(noise_flag_o, k[0], "noise");
         rd(1'b1);
         chk(noise_flag_o, 1'b0, "noise clear");
         chk(rx_available_flag_o, 1'b0, "available");
      end
      $display("test noise done");
      for (int k = 1; k < 4; k++) rcv(9'h011 * 9'(k), 3'h0);
      chk(overflow_flag_o, 1'b1, "overflow");
      rd(1'b0);
      chk(rx_data_o, 9'h011, "head after bare read");
      rd(1'b1);
      chk(overflow_flag_o, 1'b0, "overflow clear");
      chk(rx_data_o, 9'h022, "second word");
      rd(1'b1);
      chk(rx_available_flag_o, 1'b0, "third dropped");
      $display("test overrun done");
      for (int k = 0; k < 2; k++) begin
         cfg_i.two_stop <= k[0];
         rcv(9'h0C3, 3'h1);
         chk(frame_fault_flag_o, 1'b1, "frame fault");
         chk(rx_data_o, 9'h0C3, "frame word");
         if (k == 0) rd(1'b1);
      end
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk(frame_fault_flag_o, 1'b0, "frame fault reset");
      $display("test frame done");
      cfg_i.two_stop <= 1'b0;
      cfg_i.parity_on <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         cfg_i.parity_odd <= k[0];
         rcv(9'h0A7, {1'b0, k[1], 1'b0});
         chk(parity_fault_flag_o, k[1], "parity fault");
         rd(1'b1);
      end
      $display("test parity done");
      cfg_i.parity_on <= 1'b0;
      for (int k = 0; k < 5; k++) begin
         cfg_i.nine_bit_select <= k[1];
         cfg_i.address_match_mode <= !k[2];
         w = (k[1] ? 9'h100 : 9'h080) - 9'(!k[0]);
         b = irqs;
         rcv(w, 3'h0);
         chk(9'(irqs - b), 9'(k[0] | k[2]), "receive irq");
         rd(1'b1);
      end
      $display("test address done");
      for (int k = 0; k < 8; k++) begin
         irq_en_i.tx_empty_irq_enable <= k[0] ^ k[1];
         irq_en_i.tx_idle_irq_enable <= !(k[0] ^ k[1]);
         stack_full_i <= k[2];
         repeat (2) @(posedge clk_i);
         b = irqs;
         v = vecs;
         tx_idle_i <= k[0];
         tx_empty_i <= !k[0];
         repeat (4) @(posedge clk_i);
         chk(9'(irqs - b), 9'(k[1]), "transmit irq");
         chk(9'(vecs - v), 9'(k[1] & !k[2]), "vector");
         tx_idle_i <= 1'b0;
         tx_empty_i <= 1'b0;
      end
      irq_en_i <= 6'h3F;
      stack_full_i <= 1'b0;
      $display("test transmit irq done");
      cfg_i.wake_enable <= 1'b1;
      rcv(9'h155, 3'h0);
      for (int k = 0; k < 2; k++) begin
         irq_en_i.global_irq_enable <= k[0];
         chk(rx_idle_o, 1'b1, "idle before power-down");
         port_clk_on_i <= 1'b0;
         b = irqs;
         v = wakes;
         rcv(9'h0FF, 3'h0);
         chk(9'(wakes - v), 9'h001, "wake");
         port_clk_on_i <= 1'b1;
         rcv(9'h0FF, 3'h0);
         chk(9'(irqs - b), 9'(k[0]), "wake irq");
         chk(rx_data_o, 9'h055, "kept word");
      end
      rd(1'b1);
      chk(rx_available_flag_o, 1'b0, "start-up data ignored");
      $display("test wake done");
      wrap_up();
   end
endmodule
`default_nettype wire
